/* File: core/trunking_message_encoder.sv */
// Trunking message encoder: two message slots, framer, rate divider, serial out
//
// The register offsets and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
module trunking_message_encoder #(
  parameter int unsigned BURST_W    = 16,
  parameter int unsigned BUF_DEPTH  = 2
) (
  input  wire logic                     i_clk,
  input  wire logic                     i_rst_n,
  input  wire trunk_enc_pkg::reg_req_t  i_req,
  output logic [31:0]                   o_rdata,
  output logic                          o_bit_valid,
  input  wire logic                     i_bit_ready,
  output logic                          o_mod_level,
  output logic                          o_mod_sign,
  output logic                          o_busy
);
  import trunk_enc_pkg::*;

  // Bit counter width, holds a whole frame
  localparam int unsigned CNT_W = $clog2(FRAME_BITS + 1);

  // Sequencer states; LOAD lets the slot settle
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_LOAD,
    ST_SHIFT
  } tx_state_t;

  // ---------------------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------------------
  send_mode_t           send_mode;
  logic                 msg_select;
  logic                 invert;
  logic [31:0]          phase_step;
  logic [BURST_W-1:0]   burst_count;
  message_t             first_message_slot;
  message_t             second_message_slot;
  // Command pulses, a cycle after the write
  logic                 start_cmd;
  logic                 halt_cmd;

  // Transmit state
  tx_state_t            state;
  logic [FRAME_BITS-1:0] shifter;
  logic [CNT_W-1:0]     bits_left;
  logic [BURST_W-1:0]   reps_done;
  logic                 halt_pending;
  logic [31:0]          phase_acc;
  logic                 bit_strobe;
  logic                 shift_en;
  logic                 frame_end;
  logic                 last_rep;
  logic                 buf_ready;
  logic                 buf_valid;
  logic                 buf_bit;
  message_t             chosen;
  logic [PAYLOAD_BITS-1:0] payload;
  logic [FRAME_BITS-1:0] next_frame;

  // Check bits over the payload, MSB first
  function automatic logic [CHECK_BITS-1:0] calc_check(
    input logic [PAYLOAD_BITS-1:0] data
  );
    logic [CHECK_BITS-1:0] crc;
    logic                  fb;
    crc = '0;
    for (int i = PAYLOAD_BITS - 1; i >= 0; i--) begin
      fb  = crc[CHECK_BITS-1] ^ data[i];
      crc = {crc[CHECK_BITS-2:0], 1'b0} ^ (fb ? CHECK_POLY : '0);
    end
    return crc;
  endfunction : calc_check

  // Pull a message out of its two register halves
  function automatic message_t unpack_msg(input logic [63:0] w);
    message_t m;
    m.area     = w[MSG_AREA_LSB +: AREA_BITS];
    m.goto_rpt = w[MSG_GOTO_LSB +: GOTO_BITS];
    m.home_rpt = w[MSG_HOME_LSB +: HOME_BITS];
    m.free_rpt = w[MSG_FREE_LSB +: FREE_BITS];
    m.ident    = w[MSG_IDENT_LSB +: IDENT_BITS];
    return m;
  endfunction : unpack_msg

  // Repeater word of a slot; identity reads apart
  function automatic logic [31:0] msg_word(input message_t m);
    logic [63:0] w;
    w = '0;
    w[MSG_AREA_LSB +: AREA_BITS] = m.area;
    w[MSG_GOTO_LSB +: GOTO_BITS] = m.goto_rpt;
    w[MSG_HOME_LSB +: HOME_BITS] = m.home_rpt;
    w[MSG_FREE_LSB +: FREE_BITS] = m.free_rpt;
    return w[31:0];
  endfunction : msg_word

  // Write strobe aimed at one register word
  function automatic logic wr_hit(input reg_req_t r, input logic [3:0] a);
    return r.wr && (r.addr == a);
  endfunction : wr_hit

  // ---------------------------------------------------------------------------
  // Register writes
  // ---------------------------------------------------------------------------
  // Mode, select and polarity; select may change mid-stream
  // Select and polarity land even if step is refused
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      send_mode  <= MODE_SINGLE;
      msg_select <= 1'b0;
      invert     <= 1'b0;
    end else if (wr_hit(i_req, REG_CTRL)) begin
      // Stepped mode is refused; the previous mode stays
      if (send_mode_t'(i_req.wdata[CTRL_MODE_LSB +: 2]) != MODE_STEP) begin
        send_mode <= send_mode_t'(i_req.wdata[CTRL_MODE_LSB +: 2]);
      end
      msg_select <= i_req.wdata[CTRL_SEL_BIT];
      invert     <= i_req.wdata[CTRL_INV_BIT];
    end
  end

  // Bit rate as a phase step for the fractional divider
  // A zero step stops the stream; do not write it
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      phase_step <= PHASE_STEP_DEFAULT;
    end else if (wr_hit(i_req, REG_RATE)) begin
      phase_step <= i_req.wdata;
    end
  end

  // Burst count; zero would send nothing, so it is held at one
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      burst_count <= BURST_W'(BURSTS_DEFAULT);
    end else if (wr_hit(i_req, REG_BURSTS)) begin
      burst_count <= (i_req.wdata[BURST_W-1:0] == '0) ? BURST_W'(1)
                                                      : i_req.wdata[BURST_W-1:0];
    end
  end

  // Message slots: repeaters in one word, identity in its own word.
  // A repeater write keeps the identity, so words load in any order
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      first_message_slot  <= '0;
      second_message_slot <= '0;
    end else begin
      // Area is a single bit, so only zero or one can be stored
      if (wr_hit(i_req, REG_FIRST)) begin
        first_message_slot <= unpack_msg({24'h000000, first_message_slot.ident,
                                          i_req.wdata});
      end else if (wr_hit(i_req, REG_FIRST_ID)) begin
        first_message_slot.ident <= i_req.wdata[IDENT_BITS-1:0];
      end
      if (wr_hit(i_req, REG_SECOND)) begin
        second_message_slot <= unpack_msg({24'h000000, second_message_slot.ident,
                                           i_req.wdata});
      end else if (wr_hit(i_req, REG_SECOND_ID)) begin
        second_message_slot.ident <= i_req.wdata[IDENT_BITS-1:0];
      end
    end
  end

  // Start and halt command pulses
  // A start while running is dropped by the sequencer
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      start_cmd <= 1'b0;
      halt_cmd  <= 1'b0;
    end else begin
      start_cmd <= wr_hit(i_req, REG_COMMAND) && i_req.wdata[CMD_START_BIT];
      halt_cmd  <= wr_hit(i_req, REG_COMMAND) && i_req.wdata[CMD_HALT_BIT];
    end
  end

  // ---------------------------------------------------------------------------
  // Register reads, data valid the cycle after the strobe
  // ---------------------------------------------------------------------------
  // Unmapped and write-only words read as zero
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= '0;
    end else if (i_req.rd) begin
      case (i_req.addr)
        REG_CTRL:    o_rdata <= 32'({invert, msg_select, send_mode});
        REG_RATE:    o_rdata <= phase_step;
        REG_BURSTS:  o_rdata <= 32'(burst_count);
        REG_FIRST:   o_rdata <= msg_word(first_message_slot);
        REG_SECOND:  o_rdata <= msg_word(second_message_slot);
        REG_FIRST_ID:  o_rdata <= 32'(first_message_slot.ident);
        REG_SECOND_ID: o_rdata <= 32'(second_message_slot.ident);
        REG_STATUS:  o_rdata <= 32'({reps_done, halt_pending, state != ST_IDLE});
        default:     o_rdata <= '0;
      endcase
    end else begin
      o_rdata <= '0;
    end
  end

  // ---------------------------------------------------------------------------
  // Fractional bit-rate divider
  // ---------------------------------------------------------------------------
  // Carry out of the accumulator marks a bit period; the remainder stays
  // in the accumulator, so the average rate never drifts
  // Cleared when idle: a frame's first bit waits a period
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      phase_acc  <= '0;
      bit_strobe <= 1'b0;
    end else if (state == ST_IDLE) begin
      phase_acc  <= '0;
      bit_strobe <= 1'b0;
    end else begin
      {bit_strobe, phase_acc} <= 33'(phase_acc) + 33'(phase_step);
    end
  end

  // ---------------------------------------------------------------------------
  // Framer
  // ---------------------------------------------------------------------------
  // The slot is sampled at each repetition start, so a select change
  // takes effect on the next repetition without stopping output
  assign chosen = msg_select ? second_message_slot : first_message_slot;
  assign payload    = {chosen.area, chosen.goto_rpt, chosen.home_rpt,
                       chosen.ident, chosen.free_rpt};
  assign next_frame = {SYNC_WORD, payload, calc_check(payload)};

  // A bit is pushed on each strobe; a stalled buffer holds the shifter back,
  // so a strobe meeting a full buffer is skipped
  assign shift_en  = (state == ST_SHIFT) && bit_strobe && buf_ready;
  assign frame_end = shift_en && (bits_left == CNT_W'(1));
  assign last_rep  = (send_mode == MODE_SINGLE)
                  || (send_mode == MODE_BURST && reps_done + 1'b1 >= burst_count)
                  || halt_pending;

  // Halt is remembered and acted on at the end of the running repetition
  // In single mode it is ignored; the frame ends anyway
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      halt_pending <= 1'b0;
    end else if (halt_cmd && state != ST_IDLE && send_mode != MODE_SINGLE) begin
      halt_pending <= 1'b1;
    end else if (state == ST_IDLE) begin
      halt_pending <= 1'b0;
    end
  end

  // Transmit sequencer
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state     <= ST_IDLE;
      shifter   <= '0;
      bits_left <= '0;
      reps_done <= '0;
    end else begin
      case (state)
        ST_IDLE: begin
          reps_done <= '0;
          if (start_cmd) begin
            state <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          shifter   <= next_frame;
          bits_left <= CNT_W'(FRAME_BITS);
          state     <= ST_SHIFT;
        end
        ST_SHIFT: begin
          if (shift_en) begin
            shifter   <= {shifter[FRAME_BITS-2:0], 1'b0};
            bits_left <= bits_left - 1'b1;
          end
          if (frame_end) begin
            reps_done <= reps_done + 1'b1;
            // Continuous mode keeps reloading until a halt is pending
            if (last_rep) begin
              state <= ST_IDLE;
            end else begin
              // Reload on the last push: no gap between repeats
              shifter   <= next_frame;
              bits_left <= CNT_W'(FRAME_BITS);
            end
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Output buffer and polarity
  // ---------------------------------------------------------------------------
  // Two entries let the modulator stall briefly
  bit_skid_buffer #(
    .WIDTH (1),
    .DEPTH (BUF_DEPTH)
  ) u_bit_buffer (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_data  (shifter[FRAME_BITS-1]),
    .i_valid (state == ST_SHIFT && bit_strobe),
    .o_ready (buf_ready),
    .o_data  (buf_bit),
    .o_valid (buf_valid),
    .i_ready (i_bit_ready)
  );

  assign o_bit_valid = buf_valid;
  assign o_busy      = (state != ST_IDLE) || buf_valid;

  // Level and sign registered; sign high means negative excursion
  // Both hold while no bit is offered
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_mod_level <= 1'b0;
      o_mod_sign  <= 1'b0;
    end else if (buf_valid) begin
      o_mod_level <= buf_bit;
      o_mod_sign  <= invert ? buf_bit : ~buf_bit;
    end
  end
endmodule : trunking_message_encoder

/* File: common/trunk_enc_pkg.sv */
// Package of constants, types and register map for the trunking message encoder
package trunk_enc_pkg;

  // ---------------------------------------------------------------------------
  // Clock and bit rate
  // ---------------------------------------------------------------------------
  localparam int unsigned CLK_HZ            = 200_000_000;
  // Bit rate held in tenths of a bit per second, 297.6 b/s default
  localparam int unsigned RATE_DECI_DEFAULT = 2976;
  localparam int unsigned DECI_PER_UNIT     = 10;
  // Phase step per clock for a 32-bit accumulator: rate * 2^32 / clk
  localparam logic [31:0] PHASE_STEP_DEFAULT =
    32'((64'(RATE_DECI_DEFAULT) << 32) / (64'(CLK_HZ) * 64'(DECI_PER_UNIT)));

  // ---------------------------------------------------------------------------
  // Frame layout, sent in this order
  // ---------------------------------------------------------------------------
  localparam int unsigned SYNC_BITS  = 9;
  localparam int unsigned AREA_BITS  = 1;
  localparam int unsigned GOTO_BITS  = 5;
  localparam int unsigned HOME_BITS  = 5;
  localparam int unsigned IDENT_BITS = 8;
  localparam int unsigned FREE_BITS  = 5;
  localparam int unsigned CHECK_BITS = 7;
  localparam int unsigned FRAME_BITS = SYNC_BITS + AREA_BITS + GOTO_BITS + HOME_BITS
                                     + IDENT_BITS + FREE_BITS + CHECK_BITS;
  localparam int unsigned PAYLOAD_BITS = FRAME_BITS - SYNC_BITS - CHECK_BITS;
  localparam logic [SYNC_BITS-1:0]  SYNC_WORD  = 9'h158;
  localparam logic [CHECK_BITS-1:0] CHECK_POLY = 7'h09;

  // ---------------------------------------------------------------------------
  // Register map (word indices on the plain register port)
  // ---------------------------------------------------------------------------
  localparam logic [3:0] REG_CTRL    = 4'h0;
  localparam logic [3:0] REG_RATE    = 4'h1;
  localparam logic [3:0] REG_BURSTS  = 4'h2;
  localparam logic [3:0] REG_FIRST   = 4'h3;
  localparam logic [3:0] REG_SECOND  = 4'h4;
  localparam logic [3:0] REG_STATUS  = 4'h5;
  localparam logic [3:0] REG_COMMAND = 4'h6;
  localparam logic [3:0] REG_FIRST_ID  = 4'h7;
  localparam logic [3:0] REG_SECOND_ID = 4'h8;

  // Control field positions
  localparam int unsigned CTRL_MODE_LSB = 0;
  localparam int unsigned CTRL_SEL_BIT  = 2;
  localparam int unsigned CTRL_INV_BIT  = 3;
  // Command field positions
  localparam int unsigned CMD_START_BIT = 0;
  localparam int unsigned CMD_HALT_BIT  = 1;
  // Message field positions in a message register
  localparam int unsigned MSG_AREA_LSB  = 0;
  localparam int unsigned MSG_GOTO_LSB  = 8;
  localparam int unsigned MSG_HOME_LSB  = 16;
  localparam int unsigned MSG_FREE_LSB  = 24;
  localparam int unsigned MSG_IDENT_LSB = 32;

  localparam logic [15:0] BURSTS_DEFAULT = 16'h0001;

  typedef enum logic [1:0] {
    MODE_SINGLE = 2'h0,
    MODE_BURST  = 2'h1,
    MODE_CONT   = 2'h2,
    MODE_STEP   = 2'h3
  } send_mode_t;

  typedef struct packed {
    logic [AREA_BITS-1:0]  area;
    logic [GOTO_BITS-1:0]  goto_rpt;
    logic [HOME_BITS-1:0]  home_rpt;
    logic [IDENT_BITS-1:0] ident;
    logic [FREE_BITS-1:0]  free_rpt;
  } message_t;

  typedef struct packed {
    logic [3:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;

endpackage : trunk_enc_pkg

/* File: core/bit_skid_buffer.sv */
// Two-entry valid/ready buffer for the serial bit path
`timescale 1ns/1ps
module bit_skid_buffer #(
  parameter int unsigned WIDTH = 1,
  parameter int unsigned DEPTH = 2
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  input  wire logic [WIDTH-1:0] i_data,
  input  wire logic             i_valid,
  output logic                  o_ready,
  output logic      [WIDTH-1:0] o_data,
  output logic                  o_valid,
  input  wire logic             i_ready
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] store [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  // ---------------------------------------------------------------------------
  // Handshakes
  // ---------------------------------------------------------------------------
  assign o_ready = (count != (AW+1)'(DEPTH));
  assign o_valid = (count != '0);
  assign push    = i_valid && o_ready;
  assign pop     = o_valid && i_ready;
  assign o_data  = store[rd_ptr];

  // Storage, written only on push so a stalled reader keeps its word
  always_ff @(posedge i_clk) begin
    if (push) begin
      store[wr_ptr] <= i_data;
    end
  end

  // Pointers and occupancy
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : bit_skid_buffer

/* File: testbench/trunk_enc_checker.sv */
// Port-level assertions for the trunking message encoder
`timescale 1ns/1ps
module trunk_enc_checker
  import trunk_enc_pkg::*;
(
  input wire logic                    i_clk,
  input wire logic                    i_rst_n,
  input wire trunk_enc_pkg::reg_req_t i_req,
  input wire logic [31:0]             o_rdata,
  input wire logic                    o_bit_valid,
  input wire logic                    i_bit_ready,
  input wire logic                    o_mod_level,
  input wire logic                    o_mod_sign,
  input wire logic                    o_busy
);
  // ---------------------------------------------------------------------------
  // Helper state
  // ---------------------------------------------------------------------------
  logic inv_q;

  // Polarity as last written, so the sign can be tied to the level
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      inv_q <= 1'b0;
    end else if (i_req.wr && i_req.addr == REG_CTRL) begin
      inv_q <= i_req.wdata[CTRL_INV_BIT];
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  rdata_idle_a: assert property (!$past(i_req.rd) |-> o_rdata == 32'h0)
    else $error("read data seen outside a read reply");
  unmapped_read_a: assert property (i_req.rd && i_req.addr > REG_SECOND_ID |=> o_rdata == 32'h0)
    else $error("unmapped read did not return zero");
  bit_hold_a: assert property (o_bit_valid && !i_bit_ready |=> o_bit_valid)
    else $error("stalled bit dropped");
  valid_busy_a: assert property (o_bit_valid |-> o_busy)
    else $error("bit offered while idle");
  start_busy_a: assert property (i_req.wr && i_req.addr == REG_COMMAND
    && i_req.wdata[CMD_START_BIT] |-> ##[1:3] o_busy) else $error("start left encoder idle");
  sign_map_a: assert property ($past(o_bit_valid) && $past(i_rst_n)
    |-> o_mod_sign == ($past(inv_q) ? o_mod_level : !o_mod_level)) else $error("wrong polarity");
  idle_status_a: assert property ((!o_busy && !i_req.wr) [*3] ##0
    (i_req.rd && i_req.addr == REG_STATUS) |=> !o_rdata[0]) else $error("idle shows running");
  step_ignored_a: assert property (i_req.wr && i_req.addr == REG_CTRL
    && i_req.wdata[1:0] == 2'h3 ##1 i_req.rd && i_req.addr == REG_CTRL
    |=> o_rdata[1:0] != 2'h3) else $error("stepped mode accepted");
  burst_zero_a: assert property (i_req.wr && i_req.addr == REG_BURSTS
    && i_req.wdata[15:0] == 16'h0 ##1 i_req.rd && i_req.addr == REG_BURSTS
    |=> o_rdata[15:0] == 16'h0001) else $error("burst count zero not held as one");
endmodule : trunk_enc_checker

/* File: testbench/mod_sink_model.sv */
// Far-side model: modulator input that takes bits promptly or with stalls
`timescale 1ns/1ps
module mod_sink_model (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_slow,
  output logic      o_ready
);
  // ---------------------------------------------------------------------------
  // Acceptance pacing
  // ---------------------------------------------------------------------------
  logic [2:0] phase;

  // Slow mode opens one cycle in eight, long enough to fill the buffer
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      phase   <= 3'h0;
      o_ready <= 1'b0;
    end else begin
      phase   <= phase + 3'h1;
      o_ready <= !i_slow || (phase == 3'h0);
    end
  end
endmodule : mod_sink_model

/* File: testbench/trunking_message_encoder_bench.sv */
// Self-checking bench of the trunking message encoder
`timescale 1ns/1ps
module trunking_message_encoder_bench;
  import trunk_enc_pkg::*;
  typedef struct packed {logic lvl; logic inv;} exp_bit_t;
  logic        i_clk, i_rst_n, i_bit_ready, o_bit_valid, o_mod_level, o_mod_sign, o_busy, slow;
  reg_req_t    i_req;
  logic [31:0] o_rdata, slot_a, slot_b;
  logic [7:0]  id_a, id_b;
  exp_bit_t    bq[$];
  logic [63:0] rq[$];
  int          error_cnt, comparisons, bit_cnt, seed, base;

  // ---------------------------------------------------------------------------
  // Design, far side and clock
  // ---------------------------------------------------------------------------
  trunking_message_encoder dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_req(i_req),
    .o_rdata(o_rdata), .o_bit_valid(o_bit_valid), .i_bit_ready(i_bit_ready),
    .o_mod_level(o_mod_level), .o_mod_sign(o_mod_sign), .o_busy(o_busy));
  mod_sink_model sink (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_slow(slow), .o_ready(i_bit_ready));

  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end

  // ---------------------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------------------
  task automatic fail(input string msg);
    error_cnt++;
    $display("[ERR] %0t %s", $time, msg);
  endtask : fail

  task automatic finish_test();
    $display("Counts: %0d mismatches in %0d comparisons", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : finish_test

  // One strobe cycle; back-to-back calls reassign the request only once per edge
  task automatic bus(input logic [3:0] a, input logic [31:0] d, input logic w, input logic r);
    i_req <= '{addr: a, wdata: d, wr: w, rd: r};
    @(posedge i_clk);
  endtask : bus

  task automatic bus_idle(input int n);
    i_req <= '0;
    repeat (n) @(posedge i_clk);
  endtask : bus_idle

  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    bus(a, d, 1'b1, 1'b0);
  endtask : wr_reg

  task automatic rd_reg(input logic [3:0] a, input logic [31:0] e,
                        input logic [31:0] m = 32'hffffffff);
    rq.push_back({m, e});
    bus(a, 32'h0, 1'b0, 1'b1);
  endtask : rd_reg

  // Sync, area, goto, home, identity, free, then check bits
  task automatic push_frame(input logic [31:0] s, input logic [7:0] id, input logic inv,
                            input int n);
    logic [32:0]           f;
    logic [CHECK_BITS-1:0] c;
    logic                  fb;
    f = {SYNC_WORD, s[0], s[12:8], s[20:16], id, s[28:24]};
    c = '0;
    for (int i = PAYLOAD_BITS - 1; i >= 0; i--) begin
      fb = c[CHECK_BITS-1] ^ f[i];
      c  = {c[CHECK_BITS-2:0], 1'b0} ^ (fb ? CHECK_POLY : '0);
    end
    repeat (n) begin
      for (int i = 32; i >= 0; i--) bq.push_back('{f[i], inv});
      for (int i = CHECK_BITS - 1; i >= 0; i--) bq.push_back('{c[i], inv});
    end
  endtask : push_frame

  // Sampling on the falling edge keeps clear of the launch edge
  task automatic wait_bits(input int n);
    int k;
    k = 0;
    while (bit_cnt < n && k < 20000) begin
      @(negedge i_clk);
      k++;
    end
    @(posedge i_clk);
    if (bit_cnt < n) begin
      fail("bit wait ran out");
      finish_test();
    end
  endtask : wait_bits

  task automatic wait_idle();
    int k;
    k = 0;
    while ((o_busy !== 1'b0 || bq.size() != 0) && k < 20000) begin
      @(negedge i_clk);
      k++;
    end
    @(posedge i_clk);
    if (k >= 20000) begin
      fail("encoder never went idle");
      finish_test();
    end
  endtask : wait_idle

  // ---------------------------------------------------------------------------
  // Monitor: read replies and every bit taken by the far side
  // ---------------------------------------------------------------------------
  initial begin
    exp_bit_t    e;
    logic [63:0] r;
    logic        take, rd_flag;
    rd_flag = 1'b0;
    forever begin
      @(negedge i_clk);
      if (rd_flag) begin
        comparisons++;
        r = rq.pop_front();
        if ((o_rdata & r[63:32]) !== r[31:0]) fail("read data mismatch");
      end
      rd_flag = i_req.rd;
      take = o_bit_valid && i_bit_ready;
      @(posedge i_clk);
      #1;
      if (take === 1'b1) begin
        bit_cnt++;
        comparisons++;
        if (bq.size() == 0) begin
          fail("bit outside any expected frame");
        end else begin
          e = bq.pop_front();
          if (o_mod_level !== e.lvl) fail("frame bit mismatch");
          if (o_mod_sign !== (e.inv ? e.lvl : ~e.lvl)) fail("bad sign");
        end
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    seed = 23;
    error_cnt = 0;
    comparisons = 0;
    bit_cnt = 0;
    i_rst_n = 1'b0;
    i_req = '0;
    slow = 1'b0;
    repeat (4) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(posedge i_clk);
    // Defaults, an unmapped place, and both slots loaded with random fields
    rd_reg(REG_RATE, PHASE_STEP_DEFAULT);
    rd_reg(REG_BURSTS, 32'(BURSTS_DEFAULT));
    rd_reg(4'hf, 32'h0);
    slot_a = $random(seed);
    slot_b = $random(seed);
    id_a = 8'($random(seed));
    id_b = 8'($random(seed));
    wr_reg(REG_FIRST_ID, 32'(id_a));
    wr_reg(REG_SECOND_ID, 32'(id_b));
    wr_reg(REG_FIRST, slot_a);
    wr_reg(REG_SECOND, slot_b);
    rd_reg(REG_FIRST, slot_a & 32'h1f1f1f01);
    rd_reg(REG_SECOND, slot_b & 32'h1f1f1f01);
    rd_reg(REG_FIRST_ID, 32'(id_a));
    rd_reg(REG_SECOND_ID, 32'(id_b));
    wr_reg(REG_RATE, 32'h80000000);
    // Single shot from each slot, normal then inverted
    wr_reg(REG_CTRL, 32'h0);
    push_frame(slot_a, id_a, 1'b0, 1);
    wr_reg(REG_COMMAND, 32'h1);
    bus_idle(1);
    wait_idle();
    wr_reg(REG_CTRL, 32'hc);
    push_frame(slot_b, id_b, 1'b1, 1);
    wr_reg(REG_COMMAND, 32'h1);
    bus_idle(1);
    wait_idle();
    bus_idle(100);
    // Stepped mode refused, zero burst count held as one
    wr_reg(REG_CTRL, 32'hf);
    rd_reg(REG_CTRL, 32'hc);
    wr_reg(REG_BURSTS, 32'h0);
    rd_reg(REG_BURSTS, 32'h1);
    // Burst of three into a stalling receiver; a second start is ignored
    wr_reg(REG_BURSTS, 32'h3);
    wr_reg(REG_CTRL, 32'h1);
    slow <= 1'b1;
    push_frame(slot_a, id_a, 1'b0, 3);
    base = bit_cnt;
    wr_reg(REG_COMMAND, 32'h1);
    bus_idle(1);
    wait_bits(base + 20);
    wr_reg(REG_COMMAND, 32'h1);
    bus_idle(1);
    wait_idle();
    slow <= 1'b0;
    // Continuous: switch slot while running, halt in mid-frame
    wr_reg(REG_CTRL, 32'h2);
    push_frame(slot_a, id_a, 1'b0, 2);
    push_frame(slot_b, id_b, 1'b0, 1);
    base = bit_cnt;
    wr_reg(REG_COMMAND, 32'h1);
    bus_idle(1);
    wait_bits(base + 56);
    wr_reg(REG_CTRL, 32'h6);
    bus_idle(1);
    wait_bits(base + 102);
    wr_reg(REG_COMMAND, 32'h2);
    bus_idle(1);
    wait_idle();
    bus_idle(3);
    rd_reg(REG_STATUS, 32'h0, 32'h3);
    bus_idle(3);
    finish_test();
  end
endmodule : trunking_message_encoder_bench

bind trunking_message_encoder trunk_enc_checker chk (.i_clk(i_clk), .i_rst_n(i_rst_n),
  .i_req(i_req), .o_rdata(o_rdata), .o_bit_valid(o_bit_valid), .i_bit_ready(i_bit_ready),
  .o_mod_level(o_mod_level), .o_mod_sign(o_mod_sign), .o_busy(o_busy));
